/* core/wkr_regs.vh */
// Purpose: constants for the wake event indication and ready block
// Assumes: 10 MHz sys_clk
// Notes:   offsets are byte addresses on the host register port
//
// Summary of operation
// (R1) Two-bit wake cause: none, energy, frame, multiple
// (R2) Writing one clears a cause bit
// (R3) Cause clear only in D0 with ready
// (R4) Cause bit clears only after sources clear
// (R5) Pulse select one: output active 50 ms
// (R6) Pulse select zero: output held active
// (R7) Output drops on cause clear or when both event enables clear
// (R8) Polarity bit: one high, zero low, default zero
// (R9) Open-drain ignores polarity, always active low
// (R10) Output driven only when output enable set
// (R11) Output enable does not gate wake interrupt
// (R12) Ready flag set once device stabilised
// (R13) Control register readable in every power state
// (R14) Host polls ready before normal use
// (R15) Host accesses nothing else while not ready
// (R16) Host reads only config and control while not ready
// (R17) Power state: D0, D1 frame, D2 energy, reserved
// (R18) Enabled event drives output and always interrupt
// (R19) Driver type: zero open-drain, one push-pull
// (R20) Any write to byte test register wakes device
// (R21) Different second event gives multiple code
`ifndef WKR_REGS_VH
`define WKR_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define WKR_OFF_PMCS        8'h84
`define WKR_OFF_BYTE_TEST   8'h64
`define WKR_OFF_HARDWARE_CONFIG_REGISTER      8'h74

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WKR_BIT_READY       0
`define WKR_BIT_OUT_EN      1
`define WKR_BIT_POL         2
`define WKR_BIT_PULSE       3
`define WKR_BIT_CAUSE_LO    4
`define WKR_BIT_CAUSE_HI    5
`define WKR_BIT_DRV_TYPE    6
`define WKR_BIT_ENERGY_DETECT_EVENT_ENABLE       8
`define WKR_BIT_WF_EN       9
`define WKR_BIT_PS_LO       12
`define WKR_BIT_PS_HI       13

// ----------------------------------------
// Encodings and reset values
// ----------------------------------------
`define WKR_CAUSE_NONE      2'h0
`define WKR_CAUSE_ENERGY    2'h1
`define WKR_CAUSE_FRAME     2'h2
`define WKR_CAUSE_MULTI     2'h3
`define WKR_PS_D0           2'h0
`define WKR_PS_D1           2'h1
`define WKR_PS_D2           2'h2
`define WKR_PS_RSVD         2'h3
`define WKR_ZERO32          32'h0000_0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define WKR_CLK_HZ          10000000
`define WKR_PULSE_MS        50
`define WKR_PULSE_CYC       ((`WKR_CLK_HZ / 1000) * `WKR_PULSE_MS)
`define WKR_SETTLE_CYC      16
`define WKR_CNT_W           20

`endif

/* core/wkr_sync.v */
// Purpose: two-flop synchroniser for pin-level event inputs
// Assumes: single sys_clk domain
// Notes:   first stage is read only by the second stage
`timescale 1ns/10ps
`default_nettype none

module wkr_sync #(
  parameter W = 2
) (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         sys_rst,
  // Data
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] meta_reg;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_reg <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

`default_nettype wire

/* core/wkr_top.v */
// Purpose: wake cause reporting, wake output pin and device ready flag
// Assumes: host register port on sys_clk; event pins asynchronous
// Notes:   event source flags are levels held until their owner clears them
`timescale 1ns/10ps
`default_nettype none
`include "wkr_regs.vh"

module wkr_top #(
  parameter PULSE_CYC  = `WKR_PULSE_CYC,
  parameter SETTLE_CYC = `WKR_SETTLE_CYC
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        sys_rst,
  // Host register port
  input  wire [7:0]  host_addr,
  input  wire        host_wr,
  input  wire        host_rd,
  input  wire [31:0] host_wdata,
  output reg  [31:0] host_rdata,
  output reg         host_rvalid,
  // Event sources (asynchronous levels)
  input  wire        energy_src,
  input  wire        frame_src,
  // Wake pin as two signals
  output reg         wake_event_output_o,
  output reg         wake_event_output_oe,
  // Internal status
  output reg         wake_interrupt,
  output reg         device_ready,
  output reg  [1:0]  power_state_select
);

  // ----------------------------------------
  // State machine codes
  // ----------------------------------------
  localparam ST_SETTLE = 2'b00;
  localparam ST_RUN    = 2'b01;
  localparam ST_LOW    = 2'b10;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg  [1:0]             st_reg;
  reg  [1:0]             st_next;
  reg  [`WKR_CNT_W-1:0]  settle_reg;
  reg  [1:0]             cause_reg;
  reg  [1:0]             cause_next;
  reg                    out_en_reg;
  reg                    pol_reg;
  reg                    pulse_sel_reg;
  reg                    drv_type_reg;
  reg                    energy_detect_event_enable_reg;
  reg                    wf_en_reg;
  reg                    active_reg;
  reg                    active_next;
  reg  [`WKR_CNT_W-1:0]  pulse_reg;
  reg  [`WKR_CNT_W-1:0]  pulse_next;
  reg  [1:0]             src_prev_reg;
  wire [1:0]             src_sync;
  wire                   ed_hit;
  wire                   wf_hit;
  wire                   ed_rise;
  wire                   wf_rise;
  wire                   any_rise;
  wire                   wr_pmcs;
  wire                   wr_bt;
  wire                   clr_ok;
  wire                   clr_lo;
  wire                   clr_hi;
  wire [31:0]            pmcs_view;

  // ----------------------------------------
  // Event synchronisation
  // ----------------------------------------
  wkr_sync #(
    .W (2)
  ) u_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .async_in ({frame_src, energy_src}),
    .sync_out (src_sync)
  );

  // Enabled sources only count as wake events
  assign ed_hit   = src_sync[0] & energy_detect_event_enable_reg;                     // see (R18)
  assign wf_hit   = src_sync[1] & wf_en_reg;                     // see (R18)
  assign ed_rise  = ed_hit & ~src_prev_reg[0];
  assign wf_rise  = wf_hit & ~src_prev_reg[1];
  assign any_rise = ed_rise | wf_rise;

  // ----------------------------------------
  // Host decode
  // ----------------------------------------
  assign wr_pmcs = host_wr & (host_addr == `WKR_OFF_PMCS);
  assign wr_bt   = host_wr & (host_addr == `WKR_OFF_BYTE_TEST);
  // Clearing only allowed in D0 with ready set
  assign clr_ok  = wr_pmcs & device_ready &
                   (power_state_select == `WKR_PS_D0);           // see (R3)
  assign clr_lo  = clr_ok & host_wdata[`WKR_BIT_CAUSE_LO];       // see (R2)
  assign clr_hi  = clr_ok & host_wdata[`WKR_BIT_CAUSE_HI];       // see (R2)

  // ----------------------------------------
  // Wake cause field
  // ----------------------------------------
  always @* begin
    cause_next = cause_reg;
    // A cause bit stays while its feeding source is still up
    if (clr_lo && !src_sync[0])                                  // see (R4)
      cause_next[0] = 1'b0;
    if (clr_hi && !src_sync[1])                                  // see (R4)
      cause_next[1] = 1'b0;
    // New events win over a clear in the same cycle; two kinds give 11b
    if (ed_rise)                                                 // see (R1)
      cause_next[0] = 1'b1;
    if (wf_rise)                                                 // see (R1)
      cause_next[1] = 1'b1;                                      // see (R21)
  end

  // ----------------------------------------
  // Wake output activity and pulse timer
  // ----------------------------------------
  always @* begin
    active_next = active_reg;
    pulse_next  = pulse_reg;
    if (pulse_sel_reg && pulse_reg != {`WKR_CNT_W{1'b0}}) begin
      pulse_next = pulse_reg - 1'b1;
      if (pulse_reg == {{(`WKR_CNT_W-1){1'b0}}, 1'b1})
        active_next = 1'b0;                                      // see (R5)
    end
    // Deactivate on cleared cause or on both enables off
    if (cause_next == `WKR_CAUSE_NONE || (!energy_detect_event_enable_reg && !wf_en_reg)) begin
      active_next = 1'b0;                                        // see (R7)
      pulse_next  = {`WKR_CNT_W{1'b0}};
    end
    if (any_rise) begin
      active_next = 1'b1;                                        // see (R6)
      pulse_next  = pulse_sel_reg ? PULSE_CYC[`WKR_CNT_W-1:0]    // see (R5)
                                  : {`WKR_CNT_W{1'b0}};
    end
  end

  // ----------------------------------------
  // Ready sequencing
  // ----------------------------------------
  always @* begin
    st_next = st_reg;
    case (st_reg)
      ST_SETTLE: begin
        if (settle_reg == {`WKR_CNT_W{1'b0}})
          st_next = ST_RUN;
      end
      ST_RUN: begin
        if (wr_pmcs && host_wdata[`WKR_BIT_PS_HI:`WKR_BIT_PS_LO] != `WKR_PS_D0 &&
            host_wdata[`WKR_BIT_PS_HI:`WKR_BIT_PS_LO] != `WKR_PS_RSVD)
          st_next = ST_LOW;
      end
      ST_LOW: begin
        // Any data written to the byte test register wakes the device
        if (wr_bt || any_rise)                                   // see (R20)
          st_next = ST_SETTLE;
      end
      default: st_next = ST_SETTLE;
    endcase
  end

  // ----------------------------------------
  // Register file view
  // ----------------------------------------
  assign pmcs_view = {18'h00000, power_state_select, 2'h0, wf_en_reg, energy_detect_event_enable_reg,
                      1'b0, drv_type_reg, cause_reg, pulse_sel_reg, pol_reg,
                      out_en_reg, device_ready};

  // ----------------------------------------
  // Sequential logic
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg               <= ST_SETTLE;
      settle_reg           <= SETTLE_CYC[`WKR_CNT_W-1:0];
      cause_reg            <= `WKR_CAUSE_NONE;
      out_en_reg           <= 1'b0;                              // see (R10)
      pol_reg              <= 1'b0;                              // see (R8)
      pulse_sel_reg        <= 1'b0;
      drv_type_reg         <= 1'b0;
      energy_detect_event_enable_reg            <= 1'b0;
      wf_en_reg            <= 1'b0;
      active_reg           <= 1'b0;
      pulse_reg            <= {`WKR_CNT_W{1'b0}};
      src_prev_reg         <= 2'h0;
      host_rdata           <= `WKR_ZERO32;
      host_rvalid          <= 1'b0;
      wake_event_output_o  <= 1'b0;
      wake_event_output_oe <= 1'b0;
      wake_interrupt       <= 1'b0;
      device_ready         <= 1'b0;
      power_state_select   <= `WKR_PS_D0;
    end else begin
      st_reg       <= st_next;
      cause_reg    <= cause_next;
      active_reg   <= active_next;
      pulse_reg    <= pulse_next;
      src_prev_reg <= {wf_hit, ed_hit};
      if (st_reg == ST_SETTLE && settle_reg != {`WKR_CNT_W{1'b0}})
        settle_reg <= settle_reg - 1'b1;
      else if (st_reg == ST_LOW)
        settle_reg <= SETTLE_CYC[`WKR_CNT_W-1:0];
      // Ready only after the settle count runs out
      device_ready <= (st_next == ST_RUN);                       // see (R12)
      // Control writes need ready; power state field self-clears on wake
      if (wr_pmcs && device_ready) begin
        out_en_reg    <= host_wdata[`WKR_BIT_OUT_EN];
        pol_reg       <= host_wdata[`WKR_BIT_POL];
        pulse_sel_reg <= host_wdata[`WKR_BIT_PULSE];
        drv_type_reg  <= host_wdata[`WKR_BIT_DRV_TYPE];
        energy_detect_event_enable_reg     <= host_wdata[`WKR_BIT_ENERGY_DETECT_EVENT_ENABLE];
        wf_en_reg     <= host_wdata[`WKR_BIT_WF_EN];
      end
      if (st_reg == ST_RUN && st_next == ST_LOW)
        power_state_select <= host_wdata[`WKR_BIT_PS_HI:`WKR_BIT_PS_LO];  // see (R17)
      else if (st_next != ST_LOW)
        power_state_select <= `WKR_PS_D0;
      // Readable in every state, ready or not
      host_rvalid <= host_rd;                                    // see (R13)
      if (host_rd && host_addr == `WKR_OFF_PMCS)
        host_rdata <= pmcs_view;                                 // see (R13)
      else
        host_rdata <= `WKR_ZERO32;
      // Interrupt follows events regardless of output enable
      wake_interrupt <= (cause_next != `WKR_CAUSE_NONE);         // see (R11)
      // Pin: open-drain drives low only when active; push-pull uses polarity
      if (!drv_type_reg) begin
        wake_event_output_o  <= 1'b0;                            // see (R9)
        wake_event_output_oe <= out_en_reg & active_next;        // see (R19)
      end else begin
        wake_event_output_o  <= ~(active_next ^ pol_reg);        // see (R8)
        wake_event_output_oe <= out_en_reg;                      // see (R10)
      end
    end
  end

endmodule

`default_nettype wire

/* sim/wkr_asserts.sv */
// Purpose: port checks for wkr_top
// Assumes: one clock, synchronous reset
// Notes:   register contents are seen only through host reads
`timescale 1ns/10ps
`default_nettype none
module wkr_asserts #(
  parameter PULSE_CYC  = 20,
  parameter SETTLE_CYC = 4
) (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // Register port
  input wire logic [7:0]  host_addr,
  input wire logic        host_rd,
  input wire logic [31:0] host_rdata,
  input wire logic        host_rvalid,
  // Status
  input wire logic        wake_interrupt,
  input wire logic        device_ready,
  input wire logic [1:0]  power_state_select
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_rd_ctl; host_rd && host_addr == 8'h84; endsequence
  sequence s_rdy_up; $rose(device_ready); endsequence
  property p_rd_ack; host_rd |=> host_rvalid; endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("read not answered");
  property p_idle; !host_rd |=> !host_rvalid && host_rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("answer without read");
  property p_unmap; host_rd && host_addr != 8'h84 |=> host_rdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("other address not zero");
  property p_rdy_bit; s_rd_ctl |=> host_rdata[0] == $past(device_ready); endproperty
  a_rdy_bit: assert property (p_rdy_bit) else $error("ready bit wrong");
  property p_ps_bit; s_rd_ctl |=> host_rdata[13:12] == $past(power_state_select); endproperty
  a_ps_bit: assert property (p_ps_bit) else $error("state field wrong");
  property p_cause; s_rd_ctl |=> (host_rdata[5:4] != 2'h0) == $past(wake_interrupt); endproperty
  a_cause: assert property (p_cause) else $error("cause and interrupt differ");
  property p_lp_drop; $rose(power_state_select != 2'h0) |=> !device_ready; endproperty
  a_lp_drop: assert property (p_lp_drop) else $error("ready kept in low state");
  property p_rdy_d0; s_rdy_up |-> power_state_select == 2'h0 && !$past(device_ready, SETTLE_CYC); endproperty
  a_rdy_d0: assert property (p_rdy_d0) else $error("ready too early");
  property p_no_clr; wake_interrupt && !device_ready |=> wake_interrupt; endproperty
  a_no_clr: assert property (p_no_clr) else $error("cause cleared while not ready");
endmodule
bind wkr_top wkr_asserts #(.PULSE_CYC(PULSE_CYC), .SETTLE_CYC(SETTLE_CYC)) u_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .host_addr(host_addr), .host_rd(host_rd),
  .host_rdata(host_rdata), .host_rvalid(host_rvalid), .wake_interrupt(wake_interrupt),
  .device_ready(device_ready), .power_state_select(power_state_select));
`default_nettype wire

/* sim/wkr_host.sv */
// Purpose: host CPU model on the register port
// Assumes: strobes change just after sys_clk rises
// Notes:   released write data is inverted so stale data is not reused
`timescale 1ns/10ps
`default_nettype none
module wkr_host (
  // Clock
  input  wire logic        sys_clk,
  // Register port
  output var  logic [7:0]  host_addr,
  output var  logic        host_wr,
  output var  logic        host_rd,
  output var  logic [31:0] host_wdata,
  input  wire logic [31:0] host_rdata,
  input  wire logic        host_rvalid
);
  initial begin
    host_addr = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 32'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge sys_clk);
    host_wr <= 1'b0;
    host_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge sys_clk);
    host_rd <= 1'b0;
    @(posedge sys_clk);
    d = host_rvalid ? host_rdata : 32'hFFFF_FFFF;
  endtask
  // Only the control register is touched until ready reads back set
  task automatic wait_ready;
    logic [31:0] d;
    d = 32'h0;
    for (int i = 0; i < 40 && d[0] !== 1'b1; i++) rd(8'h84, d);
  endtask
endmodule
`default_nettype wire

/* sim/wkr_top_tb.sv */
// Purpose: self-checking bench for wkr_top
// Assumes: short pulse and settle counts
// Notes:   event sources are raised by the bench, host is modelled
`timescale 1ns/10ps
`default_nettype none
module wkr_top_tb;
  logic sys_clk = 1'b0;
  logic sys_rst, host_wr, host_rd, host_rvalid, energy_src, frame_src;
  logic pin_o, pin_oe, wake_interrupt, device_ready;
  logic [7:0] host_addr;
  logic [31:0] host_wdata, host_rdata;
  logic [1:0] power_state_select;
  int err_count = 0;
  int n_tests = 0;
  always #50 sys_clk = ~sys_clk;
  wkr_top #(.PULSE_CYC(20), .SETTLE_CYC(4)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .energy_src(energy_src),
    .frame_src(frame_src), .wake_event_output_o(pin_o), .wake_event_output_oe(pin_oe),
    .wake_interrupt(wake_interrupt), .device_ready(device_ready),
    .power_state_select(power_state_select));
  wkr_host host (.sys_clk(sys_clk), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    host.rd(a, d);
    chk("read", e, d);
  endtask
  // Pin registers see a control write one edge late, so look two edges on
  task automatic pin(input logic [1:0] e);
    repeat (2) @(posedge sys_clk);
    chk("pin oe,o", {30'h0, e}, {30'h0, pin_oe, pin_o});
  endtask
  // Sources settle through two sync stages; four edges covers that
  task automatic ev(input logic e, input logic f);
    @(posedge sys_clk);
    energy_src <= e;
    frame_src <= f;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic t_reset;
    rdc(8'h84, 32'h0);
    pin(2'b00);
    host.wait_ready();
    rdc(8'h84, 32'h1);
    rdc(8'h74, 32'h0);
  endtask
  task automatic t_static;
    host.wr(8'h84, 32'h146);
    pin(2'b10);
    ev(1'b1, 1'b0);
    rdc(8'h84, 32'h157);
    repeat (30) @(posedge sys_clk);
    pin(2'b11);
    host.wr(8'h84, 32'h156);
    rdc(8'h84, 32'h157);
    ev(1'b0, 1'b0);
    host.wr(8'h84, 32'h146);
    rdc(8'h84, 32'h157);
    host.wr(8'h84, 32'h156);
    rdc(8'h84, 32'h147);
    pin(2'b10);
  endtask
  task automatic t_multi;
    host.wr(8'h84, 32'h346);
    ev(1'b1, 1'b0);
    ev(1'b1, 1'b1);
    rdc(8'h84, 32'h377);
    ev(1'b0, 1'b0);
    host.wr(8'h84, 32'h376);
    ev(1'b0, 1'b1);
    rdc(8'h84, 32'h367);
    ev(1'b0, 1'b0);
    host.wr(8'h84, 32'h366);
    rdc(8'h84, 32'h347);
  endtask
  task automatic t_pulse;
    int n;
    host.wr(8'h84, 32'h14A);
    pin(2'b11);
    n = 0;
    energy_src <= 1'b1;
    repeat (40) begin
      @(posedge sys_clk);
      if (pin_o === 1'b0) n++;
    end
    chk("pulse cycles", 32'd20, n);
    host.wr(8'h84, 32'h148);
    repeat (2) @(posedge sys_clk);
    chk("oe", 32'h0, {31'h0, pin_oe});
    chk("interrupt", 32'h1, {31'h0, wake_interrupt});
    ev(1'b0, 1'b0);
    host.wr(8'h84, 32'h158);
    rdc(8'h84, 32'h149);
  endtask
  task automatic t_drain;
    host.wr(8'h84, 32'h106);
    pin(2'b00);
    ev(1'b1, 1'b0);
    pin(2'b10);
    host.wr(8'h84, 32'h006);
    @(posedge sys_clk);
    pin(2'b00);
    ev(1'b0, 1'b0);
    host.wr(8'h84, 32'h016);
    rdc(8'h84, 32'h007);
  endtask
  task automatic t_lowpow;
    host.wr(8'h84, 32'h3000);
    rdc(8'h84, 32'h1);
    host.wr(8'h84, 32'h2100);
    repeat (3) @(posedge sys_clk);
    chk("state", 32'h2, {30'h0, power_state_select});
    chk("ready", 32'h0, {31'h0, device_ready});
    rdc(8'h84, 32'h2100);
    host.wr(8'h64, 32'hA5A5_A5A5);
    host.wait_ready();
    chk("state", 32'h0, {30'h0, power_state_select});
    host.wr(8'h84, 32'h1200);
    repeat (3) @(posedge sys_clk);
    chk("state", 32'h1, {30'h0, power_state_select});
    ev(1'b0, 1'b1);
    host.wait_ready();
    rdc(8'h84, 32'h221);
    ev(1'b0, 1'b0);
    // Enter D2 with the cause kept, then try to clear it while not ready
    host.wr(8'h84, 32'h2200);
    host.wr(8'h84, 32'h0220);
    host.wr(8'h64, 32'h0000_0000);
    host.wait_ready();
    rdc(8'h84, 32'h221);
    host.wr(8'h84, 32'h220);
    rdc(8'h84, 32'h201);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    sys_rst = 1'b1;
    energy_src = 1'b0;
    frame_src = 1'b0;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_static();
    t_multi();
    t_pulse();
    t_drain();
    t_lowpow();
    end_sim();
  end
  // Whole run is well under a thousand cycles
  initial begin
    #1000000;
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
